/* hdl/cgl_pkg.sv */
// Constants for the configurable glue logic unit
package cgl_pkg;

    // ========================================
    // Bus and table sizes
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 8;
    localparam int NUM_LUT  = 2;
    localparam int NUM_IN   = 3;
    localparam int TRUTH_W  = 8;

    // ========================================
    // Register offsets
    localparam logic [3:0] OFS_GLOBAL_CTRL = 4'h0;
    localparam logic [3:0] OFS_SEQ_CTRL    = 4'h1;
    localparam logic [3:0] OFS_LUT_BASE    = 4'h2;
    localparam logic [3:0] OFS_LUT_STRIDE  = 4'h4;
    localparam logic [3:0] OFS_CTRLA       = 4'h0;
    localparam logic [3:0] OFS_CTRLB       = 4'h1;
    localparam logic [3:0] OFS_CTRLC       = 4'h2;
    localparam logic [3:0] OFS_TRUTH       = 4'h3;
    localparam logic [3:0] OFS_STATUS      = 4'hA;

    // ========================================
    // Field positions
    localparam int GLOBAL_EN_BIT  = 0;
    localparam int LUT_EN_BIT     = 0;
    localparam int CLK_SOURCE_BIT = 1;
    localparam int FILT_LSB       = 2;
    localparam int EDGE_BIT       = 4;
    localparam int INSEL_W        = 4;
    localparam int INSEL_LO_LSB   = 0;
    localparam int INSEL_HI_LSB   = 4;
    localparam int SEQ_FUNC_W     = 3;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_REG   = 8'h00;
    localparam logic [2:0] RST_SEQ   = 3'h0;

    // ========================================
    // Input source codes
    localparam logic [3:0] IN_MASK       = 4'h0;
    localparam logic [3:0] IN_FEEDBACK   = 4'h1;
    localparam logic [3:0] IN_LINK       = 4'h2;
    localparam logic [3:0] IN_EVENT0     = 4'h3;
    localparam logic [3:0] IN_EVENT1     = 4'h4;
    localparam logic [3:0] IN_PIN        = 4'h5;
    localparam logic [3:0] IN_COMPARATOR = 4'h6;
    localparam logic [3:0] IN_TIMER      = 4'h7;
    localparam logic [3:0] IN_UART       = 4'h8;
    localparam logic [3:0] IN_SPI        = 4'h9;

    // ========================================
    // Output stage and sequential modes
    localparam logic [1:0] FILT_NONE   = 2'h0;
    localparam logic [1:0] FILT_SYNC   = 2'h1;
    localparam logic [1:0] FILT_SPIKE  = 2'h2;
    localparam logic [2:0] SEQ_OFF     = 3'h0;
    localparam logic [2:0] SEQ_DFF     = 3'h1;
    localparam logic [2:0] SEQ_JK      = 3'h2;
    localparam logic [2:0] SEQ_DLATCH  = 3'h3;
    localparam logic [2:0] SEQ_RS      = 3'h4;

endpackage

/* hdl/cgl_lut_stage.sv */
// One lookup table with its synchroniser, spike filter and edge detector
`timescale 1ns/1ps
module cgl_lut_stage
    import cgl_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic         i_enable,
    input  wire logic         i_clk_en,
    input  wire logic [2:0]   i_in,
    input  wire logic [7:0]   i_truth,
    input  wire logic [1:0]   i_filt_sel,
    input  wire logic         i_edge_det,
    output logic              o_out
);

    logic       look_r;
    logic       sync1_r;
    logic       sync2_r;
    logic       sync3_r;
    logic       spike_r;
    logic       edge_prev_r;
    logic       stage_val;

    // ========================================
    // Table lookup, input 2 is the index MSB
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !i_enable) begin
            look_r <= 1'b0;
        end else if (i_clk_en) begin
            look_r <= i_truth[i_in];
        end
    end

    // ========================================
    // Synchroniser and spike filter, cleared while disabled
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !i_enable) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else if (i_clk_en) begin
            sync1_r <= look_r;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !i_enable) begin
            spike_r <= 1'b0;
        end else if (i_clk_en && (sync1_r == sync2_r) && (sync2_r == sync3_r)) begin
            spike_r <= sync3_r;
        end
    end

    always_comb begin
        case (i_filt_sel)
            FILT_SYNC:  stage_val = sync2_r;
            FILT_SPIKE: stage_val = spike_r;
            default:    stage_val = look_r;
        endcase
    end

    // ========================================
    // Rising edge detector
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !i_enable) begin
            edge_prev_r <= 1'b0;
        end else if (i_clk_en) begin
            edge_prev_r <= stage_val;
        end
    end

    assign o_out = i_edge_det ? (stage_val & ~edge_prev_r) : stage_val;

    lookup_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_enable && i_clk_en |=> !i_enable || (look_r == $past(i_truth[i_in])))
        else $error("table output does not follow truth bit");

    filter_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !i_enable |=> !spike_r && !sync1_r && !edge_prev_r)
        else $error("output stage not cleared while disabled");

endmodule

/* hdl/cgl_seq_element.sv */
// Shared sequential element of the table pair
`timescale 1ns/1ps
module cgl_seq_element
    import cgl_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic         i_enable,
    input  wire logic         i_clk_en,
    input  wire logic [2:0]   i_sel,
    input  wire logic         i_even,
    input  wire logic         i_odd,
    output logic              o_q
);

    logic q_r;

    // Even table drives D/J/S, odd table drives G/K/R
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !i_enable) begin
            q_r <= 1'b0;
        end else if (i_clk_en) begin
            case (i_sel)
                SEQ_DFF:    q_r <= i_odd ? i_even : q_r;
                SEQ_DLATCH: q_r <= i_odd ? i_even : q_r;
                SEQ_JK:     q_r <= (i_even & ~q_r) | (~i_odd & q_r);
                SEQ_RS:     q_r <= (i_even & ~i_odd) | (q_r & ~i_odd) | (q_r & i_even);
                default:    q_r <= 1'b0;
            endcase
        end
    end

    assign o_q = q_r;

    dff_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_enable && i_clk_en && i_sel == SEQ_DFF && i_odd ##1 i_enable |-> q_r == $past(i_even))
        else $error("gated flip-flop did not load");

    jk_toggle_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_enable && i_clk_en && i_sel == SEQ_JK && i_even && i_odd ##1 i_enable
        |-> q_r != $past(q_r))
        else $error("JK element did not toggle");

endmodule

/* hdl/cgl_glue_logic.sv */
// Top of the configurable glue logic unit: registers, input routing, outputs
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cgl_glue_logic
    import cgl_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic [3:0]   i_addr,
    input  wire logic [7:0]   i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic      [7:0]   o_rdata,
    input  wire logic [2:0]   i_lut0_pin,
    input  wire logic [2:0]   i_lut1_pin,
    input  wire logic [1:0]   i_event,
    input  wire logic         i_comparator,
    input  wire logic         i_timer,
    input  wire logic         i_uart,
    input  wire logic         i_spi,
    output logic      [1:0]   o_lut_pin,
    output logic      [1:0]   o_lut_pin_oe,
    output logic      [1:0]   o_lut_event
);

    // ========================================
    // Decoding helpers
    function automatic logic [3:0] lut_addr(input int n, input logic [3:0] ofs);
        lut_addr = 4'(OFS_LUT_BASE + 4'(n) * OFS_LUT_STRIDE + ofs);
    endfunction

    function automatic logic route_input(
        input logic [3:0] code,
        input logic       pin,
        input logic       link,
        input logic       fb,
        input logic [1:0] evt,
        input logic [3:0] periph
    );
        case (code)
            IN_FEEDBACK:   route_input = fb;
            IN_LINK:       route_input = link;
            IN_EVENT0:     route_input = evt[0];
            IN_EVENT1:     route_input = evt[1];
            IN_PIN:        route_input = pin;
            IN_COMPARATOR: route_input = periph[0];
            IN_TIMER:      route_input = periph[1];
            IN_UART:       route_input = periph[2];
            IN_SPI:        route_input = periph[3];
            default:       route_input = 1'b0;
        endcase
    endfunction

    // ========================================
    // Register state
    logic       global_en_r;
    logic [2:0] seq_sel_r;
    logic [7:0] ctrla_r [NUM_LUT];
    logic [7:0] ctrlb_r [NUM_LUT];
    logic [7:0] ctrlc_r [NUM_LUT];
    logic [7:0] truth_r [NUM_LUT];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic [1:0] lut_run;
    logic [1:0] lut_ce;
    logic [1:0] stage_out;
    logic [1:0] in2_prev_r;
    logic [2:0] lut_in [NUM_LUT];
    logic [2:0] pin_in [NUM_LUT];
    logic [3:0] periph;
    logic       seq_q;
    logic [1:0] out_nxt;
    logic [1:0] pin_r;
    logic [1:0] oe_r;
    logic [1:0] event_r;

    assign periph    = {i_spi, i_uart, i_timer, i_comparator};
    assign pin_in[0] = i_lut0_pin;
    assign pin_in[1] = i_lut1_pin;

    // ========================================
    // Global and sequential control
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            global_en_r <= 1'b0;
        end else if (i_wr && i_addr == OFS_GLOBAL_CTRL) begin
            global_en_r <= i_wdata[GLOBAL_EN_BIT];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            seq_sel_r <= RST_SEQ;
        end else if (i_wr && i_addr == OFS_SEQ_CTRL && !ctrla_r[0][LUT_EN_BIT]) begin
            seq_sel_r <= i_wdata[SEQ_FUNC_W-1:0];
        end
    end

    // ========================================
    // Per-table control, routing and output stage
    genvar n;
    genvar k;
    generate
        for (n = 0; n < NUM_LUT; n++) begin : g_lut
            // Enable always writable; other bits only from the disabled state
            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    ctrla_r[n] <= RST_REG;
                end else if (i_wr && i_addr == lut_addr(n, OFS_CTRLA)) begin
                    if (!ctrla_r[n][LUT_EN_BIT]) begin
                        ctrla_r[n] <= i_wdata;
                    end else begin
                        ctrla_r[n][LUT_EN_BIT] <= i_wdata[LUT_EN_BIT];
                    end
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    ctrlb_r[n] <= RST_REG;
                end else if (i_wr && i_addr == lut_addr(n, OFS_CTRLB)
                             && !ctrla_r[n][LUT_EN_BIT]) begin
                    ctrlb_r[n] <= i_wdata;
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    ctrlc_r[n] <= RST_REG;
                end else if (i_wr && i_addr == lut_addr(n, OFS_CTRLC)
                             && !ctrla_r[n][LUT_EN_BIT]) begin
                    ctrlc_r[n] <= i_wdata;
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    truth_r[n] <= RST_REG;
                end else if (i_wr && i_addr == lut_addr(n, OFS_TRUTH)) begin
                    truth_r[n] <= i_wdata;
                end
            end

            // Input select: masked inputs read as zero
            for (k = 0; k < NUM_IN; k++) begin : g_in
                logic [3:0] code;
                if (k == 2) begin : g_c
                    assign code = ctrlc_r[n][INSEL_LO_LSB +: INSEL_W];
                end else if (k == 1) begin : g_b1
                    assign code = ctrlb_r[n][INSEL_HI_LSB +: INSEL_W];
                end else begin : g_b0
                    assign code = ctrlb_r[n][INSEL_LO_LSB +: INSEL_W];
                end
                assign lut_in[n][k] = route_input(code, pin_in[n][k],
                    stage_out[(n + 1) % NUM_LUT], seq_q, i_event, periph);
            end

            assign lut_run[n] = global_en_r & ctrla_r[n][LUT_EN_BIT];

            // Alternative clock: rising edge of input 2 as a clock enable
            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    in2_prev_r[n] <= 1'b0;
                end else begin
                    in2_prev_r[n] <= lut_in[n][2];
                end
            end

            assign lut_ce[n] = ctrla_r[n][CLK_SOURCE_BIT]
                             ? (lut_in[n][2] & ~in2_prev_r[n])
                             : 1'b1;

            cgl_lut_stage u_stage (
                .i_ref_clk  (i_ref_clk),
                .i_reset    (i_reset),
                .i_enable   (lut_run[n]),
                .i_clk_en   (lut_ce[n]),
                .i_in       (lut_in[n]),
                .i_truth    (truth_r[n]),
                .i_filt_sel (ctrla_r[n][FILT_LSB +: 2]),
                .i_edge_det (ctrla_r[n][EDGE_BIT]),
                .o_out      (stage_out[n])
            );
        end
    endgenerate

    // ========================================
    // Sequential element, on the even table clock
    cgl_seq_element u_seq (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_enable  (lut_run[0]),
        .i_clk_en  (lut_ce[0]),
        .i_sel     (seq_sel_r),
        .i_even    (stage_out[0]),
        .i_odd     (stage_out[1]),
        .o_q       (seq_q)
    );

    // ========================================
    // Outputs to pins and event system, no debug halt input
    always_comb begin
        out_nxt[0] = lut_run[0] & ((seq_sel_r != SEQ_OFF) ? seq_q : stage_out[0]);
        out_nxt[1] = lut_run[1] & stage_out[1];
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pin_r   <= 2'h0;
            oe_r    <= 2'h0;
            event_r <= 2'h0;
        end else begin
            pin_r   <= out_nxt;
            oe_r    <= lut_run;
            event_r <= out_nxt;
        end
    end

    assign o_lut_pin    = pin_r;
    assign o_lut_pin_oe = oe_r;
    assign o_lut_event  = event_r;

    // ========================================
    // Read port, data valid only in the cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_addr == OFS_GLOBAL_CTRL) begin
            rdata_nxt = {7'h00, global_en_r};
        end else if (i_addr == OFS_SEQ_CTRL) begin
            rdata_nxt = {5'h00, seq_sel_r};
        end else if (i_addr == OFS_STATUS) begin
            rdata_nxt = {5'h00, seq_q, stage_out};
        end
        for (int m = 0; m < NUM_LUT; m++) begin
            if (i_addr == lut_addr(m, OFS_CTRLA)) begin
                rdata_nxt = ctrla_r[m];
            end else if (i_addr == lut_addr(m, OFS_CTRLB)) begin
                rdata_nxt = ctrlb_r[m];
            end else if (i_addr == lut_addr(m, OFS_CTRLC)) begin
                rdata_nxt = ctrlc_r[m];
            end else if (i_addr == lut_addr(m, OFS_TRUTH)) begin
                rdata_nxt = truth_r[m];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= i_rd ? rdata_nxt : 8'h00;
        end
    end

    assign o_rdata = rdata_r;

    // ========================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    sequence wr_ctrla0_s;
        i_wr && i_addr == lut_addr(0, OFS_CTRLA);
    endsequence

    sequence enabling0_s;
        wr_ctrla0_s and (!ctrla_r[0][LUT_EN_BIT] && i_wdata[LUT_EN_BIT]);
    endsequence

    ctrlb_locked_a: assert property (
        ctrla_r[1][LUT_EN_BIT] |=> $stable(ctrlb_r[1]) && $stable(ctrlc_r[1]))
        else $error("table control changed while enabled");

    sequential_function_select_locked_a: assert property (
        ctrla_r[0][LUT_EN_BIT] |=> $stable(seq_sel_r))
        else $error("sequential select changed while even table on");

    enable_pass_a: assert property (
        enabling0_s |=> ctrla_r[0] == $past(i_wdata))
        else $error("protected bits lost on enabling write");

    disable_keep_a: assert property (
        wr_ctrla0_s and (ctrla_r[0][LUT_EN_BIT] && !i_wdata[LUT_EN_BIT])
        |=> !ctrla_r[0][LUT_EN_BIT] && ctrla_r[0][7:1] == $past(ctrla_r[0][7:1]))
        else $error("protected bits written on disabling write");

    global_off_a: assert property (
        !global_en_r |=> o_lut_pin == 2'h0 && o_lut_pin_oe == 2'h0)
        else $error("outputs active while unit disabled");

    mask_zero_a: assert property (
        ctrlb_r[0][INSEL_LO_LSB +: INSEL_W] == IN_MASK |-> !lut_in[0][0])
        else $error("masked input not zero");

    alt_clock_a: assert property (
        ctrla_r[0][CLK_SOURCE_BIT] && $stable(lut_in[0][2]) |-> !lut_ce[0])
        else $error("table clocked without input 2 edge");

    read_port_a: assert property (
        i_rd && i_addr == lut_addr(1, OFS_TRUTH) ##1 !i_rd |-> o_rdata == $past(truth_r[1])
        ##1 o_rdata == 8'h00)
        else $error("read data wrong or held too long");

    seq_clear_a: assert property (
        !lut_run[0] |=> !seq_q)
        else $error("sequential element not cleared with even table");

    oe_follow_a: assert property (
        global_en_r && ctrla_r[1][LUT_EN_BIT] |=> o_lut_pin_oe[1])
        else $error("pin drive missing on enabled table");

    link_route_a: assert property (
        ctrlb_r[1][INSEL_LO_LSB +: INSEL_W] == IN_LINK |-> lut_in[1][0] == stage_out[0])
        else $error("link input does not follow neighbour table");

    feedback_route_a: assert property (
        ctrlb_r[1][INSEL_LO_LSB +: INSEL_W] == IN_FEEDBACK |-> lut_in[1][0] == seq_q)
        else $error("feedback input does not follow sequential output");

    truth_open_a: assert property (
        i_wr && i_addr == lut_addr(1, OFS_TRUTH) |=> truth_r[1] == $past(i_wdata))
        else $error("truth table write lost");

endmodule

/* sim/cgl_far_side.sv */
// Model of the pins, event lines and peripherals that feed the unit
`timescale 1ns/1ps
module cgl_far_side (
    input  wire logic        i_ref_clk,
    input  wire logic [11:0] i_drive,
    output logic      [2:0]  o_lut0_pin = 3'h0,
    output logic      [2:0]  o_lut1_pin = 3'h0,
    output logic      [1:0]  o_event = 2'h0,
    output logic      [3:0]  o_periph = 4'h0
);
    // ========================================
    // Sources change just after an edge, like real synchronous outputs
    always @(posedge i_ref_clk) begin
        o_lut0_pin <= i_drive[2:0];
        o_lut1_pin <= i_drive[5:3];
        o_event    <= i_drive[7:6];
        o_periph   <= i_drive[11:8];
    end
endmodule

/* sim/cgl_glue_logic_tb.sv */
// Self-checking bench for the glue logic unit
`timescale 1ns/1ps
module cgl_glue_logic_tb;
    import cgl_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [11:0] drv = 12'h000;
    logic [7:0]  rdata;
    logic [2:0]  p0;
    logic [2:0]  p1;
    logic [1:0]  ev;
    logic [3:0]  per;
    logic [1:0]  pin;
    logic [1:0]  oe;
    logic [1:0]  lev;
    int          mismatches = 0;
    int          total_checks = 0;
    int          hits;
    logic [3:0]  codes [7] = '{IN_EVENT0, IN_EVENT1, IN_COMPARATOR, IN_TIMER,
                               IN_UART, IN_SPI, IN_PIN};
    int          bits [7] = '{6, 7, 8, 9, 10, 11, 3};
    logic [2:0]  modes [4] = '{SEQ_DFF, SEQ_JK, SEQ_DLATCH, SEQ_RS};

    always #20 clk = ~clk;

    cgl_far_side far_u (
        .i_ref_clk  (clk),
        .i_drive    (drv),
        .o_lut0_pin (p0),
        .o_lut1_pin (p1),
        .o_event    (ev),
        .o_periph   (per)
    );

    cgl_glue_logic dut_u (
        .i_ref_clk    (clk),
        .i_reset      (rst),
        .i_addr       (addr),
        .i_wdata      (wdata),
        .i_wr         (wr),
        .i_rd         (rd),
        .o_rdata      (rdata),
        .i_lut0_pin   (p0),
        .i_lut1_pin   (p1),
        .i_event      (ev),
        .i_comparator (per[0]),
        .i_timer      (per[1]),
        .i_uart       (per[2]),
        .i_spi        (per[3]),
        .o_lut_pin    (pin),
        .o_lut_pin_oe (oe),
        .o_lut_event  (lev)
    );

    // ========================================
    // Comparison, verdict and bus tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ========================================
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end

    // ========================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++)
            rdc(a[3:0], 8'h00);
        // Lookup over all eight input values
        wrr(4'h5, 8'h96);
        wrr(4'h3, 8'h55);
        wrr(4'h4, 8'h05);
        wrr(4'h0, 8'h01);
        wrr(4'h2, 8'h01);
        for (int i = 0; i < 8; i++) begin
            drv <= {9'h000, i[2:0]};
            settle(5);
            chk({7'h0, pin[0]}, (8'h96 >> i) & 8'h01);
            chk({5'h0, oe, lev[0]}, {5'h0, 2'h1, pin[0]});
        end
        // Protected fields while enabled and around enabling
        wrr(4'h3, 8'h77);
        rdc(4'h3, 8'h55);
        wrr(4'h2, 8'h05);
        rdc(4'h2, 8'h01);
        wrr(4'h1, {5'h0, SEQ_DFF});
        rdc(4'h1, 8'h00);
        wrr(4'h2, 8'h04);
        rdc(4'h2, 8'h00);
        wrr(4'h3, 8'h05);
        wrr(4'h2, 8'h05);
        rdc(4'h2, 8'h05);
        // Masked input reads as zero, through the synchroniser
        drv <= 12'h007;
        settle(8);
        chk({7'h0, pin[0]}, 8'h00);
        drv <= 12'h003;
        settle(8);
        chk({7'h0, pin[0]}, 8'h01);
        // Edge detector gives a single pulse on a held level
        drv <= 12'h000;
        wrr(4'h2, 8'h00);
        wrr(4'h2, 8'h15);
        settle(8);
        hits = 0;
        drv <= 12'h001;
        for (int c = 0; c < 12; c++) begin
            settle(1);
            if (pin[0] === 1'b1)
                hits++;
        end
        chk(hits[7:0], 8'h01);
        // Spike filter drops a one-cycle pulse and passes a held level
        drv <= 12'h000;
        wrr(4'h2, 8'h00);
        wrr(4'h2, 8'h09);
        settle(8);
        hits = 0;
        drv <= 12'h001;
        settle(1);
        drv <= 12'h000;
        for (int c = 0; c < 12; c++) begin
            settle(1);
            if (pin[0] === 1'b1)
                hits++;
        end
        chk(hits[7:0], 8'h00);
        drv <= 12'h001;
        settle(10);
        chk({7'h0, pin[0]}, 8'h01);
        // Global enable gates the outputs
        wrr(4'h0, 8'h00);
        settle(3);
        chk({6'h0, oe}, 8'h00);
        wrr(4'h0, 8'h01);
        // Event, peripheral and pin source codes on table 1 input 0
        wrr(4'h9, 8'hAA);
        for (int k = 0; k < 7; k++) begin
            wrr(4'h6, 8'h00);
            wrr(4'h7, {4'h0, codes[k]});
            wrr(4'h6, 8'h01);
            drv <= 12'h001 << bits[k];
            settle(5);
            chk({6'h0, pin[1], lev[1]}, 8'h03);
            drv <= 12'h000;
            settle(5);
            chk({7'h0, pin[1]}, 8'h00);
        end
        // Input 2 as clock: output holds between its rising edges
        wrr(4'h0, 8'h00);
        wrr(4'h2, 8'h00);
        wrr(4'h3, 8'h00);
        wrr(4'h4, 8'h05);
        wrr(4'h5, 8'h10);
        wrr(4'h2, 8'h03);
        wrr(4'h0, 8'h01);
        drv <= 12'h004;
        settle(6);
        chk({7'h0, pin[0]}, 8'h01);
        drv <= 12'h000;
        settle(6);
        chk({7'h0, pin[0]}, 8'h01);
        wrr(4'h0, 8'h00);
        wrr(4'h2, 8'h00);
        wrr(4'h2, 8'h00);
        wrr(4'h4, 8'h00);
        wrr(4'h0, 8'h01);
        // Sequential element in the DFF, JK, latch and RS modes, driven by both tables
        wrr(4'h6, 8'h00);
        wrr(4'h7, 8'h00);
        wrr(4'h6, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wrr(4'h2, 8'h00);
            wrr(4'h1, {5'h0, modes[m]});
            rdc(4'h1, {5'h0, modes[m]});
            wrr(4'h5, 8'h01);
            wrr(4'h9, (m == 1 || m == 3) ? 8'h00 : 8'h01);
            wrr(4'h2, 8'h01);
            settle(6);
            chk({7'h0, pin[0]}, 8'h01);
            wrr(4'h9, 8'h00);
            wrr(4'h5, 8'h00);
            settle(6);
            chk({7'h0, pin[0]}, 8'h01);
            wrr(4'h9, 8'h01);
            settle(6);
            chk({7'h0, pin[0]}, 8'h00);
            if (m == 1) begin
                wrr(4'h5, 8'h01);
                settle(4);
                hits = 0;
                for (int c = 0; c < 8; c++) begin
                    settle(1);
                    if (pin[0] === 1'b1)
                        hits++;
                end
                chk(hits[7:0], 8'h04);
            end
        end
        // Feedback and link sources on table 1 input 0
        wrr(4'h6, 8'h00);
        wrr(4'h7, {4'h0, IN_FEEDBACK});
        wrr(4'h9, 8'hAA);
        wrr(4'h6, 8'h01);
        wrr(4'h5, 8'h01);
        settle(8);
        chk({6'h0, pin}, 8'h03);
        wrr(4'h6, 8'h00);
        wrr(4'h7, {4'h0, IN_LINK});
        wrr(4'h6, 8'h01);
        settle(6);
        chk({7'h0, pin[1]}, 8'h01);
        wrr(4'h5, 8'h00);
        settle(6);
        chk({7'h0, pin[1]}, 8'h00);
        summarize();
    end
endmodule
